// >>> hdl/eess_synth_state.v
// enclave asynchronous-exit synthetic state loader with AXI4-Lite registers
`timescale 1ns/100ps
`include "eess_defs.vh"
module eess_synth_state #(
   parameter SAVE_CYCLES = 4                        // save-area write cycles counted; count saturates here, no timeout
) (
   input  wire        aclk,                         // core clock 250 MHz
   input  wire        aresetn,                      // sync reset, active low
   input  wire        async_enclave_exit,           // one-cycle exit request
   input  wire        save_done,                    // save-area frame write complete
   input  wire [63:0] saved_user_stack_ptr,         // stack pointer from save area
   input  wire [63:0] saved_user_frame_ptr,         // frame pointer from save area
   input  wire [63:0] entry_fs_base,                // FS base at latest entry/resume
   input  wire [63:0] entry_gs_base,                // GS base at latest entry/resume
   input  wire [63:0] cur_r8_r15,                   // representative high GPR, kept in 32-bit
   output reg         save_req,                     // request save-area write
   output reg         state_load,                   // one-cycle strobe: synthetic values valid
   output reg  [63:0] gpr_rax,                      // accumulator
   output reg  [63:0] gpr_rbx,                      // base
   output reg  [63:0] gpr_rcx,                      // counter
   output reg  [63:0] gpr_rdx,                      // data
   output reg  [63:0] gpr_rsi,                      // source
   output reg  [63:0] gpr_rdi,                      // destination
   output reg  [63:0] gpr_high,                     // value for R8-R15
   output reg  [63:0] gpr_rip,                      // instruction pointer
   output reg  [63:0] gpr_rsp,                      // stack pointer
   output reg  [63:0] gpr_rbp,                      // frame pointer
   output reg  [63:0] seg_fs_base,                  // FS base
   output reg  [63:0] seg_gs_base,                  // GS base
   output reg         x87sse_init,                  // x87/SSE to init state
   output reg  [63:0] xinit_mask,                   // extended features to init
   input  wire [7:0]  s_axi_awaddr,                 // write address
   input  wire        s_axi_awvalid,                // write address valid
   output reg         s_axi_awready,                // write address ready
   input  wire [31:0] s_axi_wdata,                  // write data
   input  wire [3:0]  s_axi_wstrb,                  // write strobes
   input  wire        s_axi_wvalid,                 // write data valid
   output reg         s_axi_wready,                 // write data ready
   output reg  [1:0]  s_axi_bresp,                  // write response
   output reg         s_axi_bvalid,                 // write response valid
   input  wire        s_axi_bready,                 // write response ready
   input  wire [7:0]  s_axi_araddr,                 // read address
   input  wire        s_axi_arvalid,                // read address valid
   output reg         s_axi_arready,                // read address ready
   output reg  [31:0] s_axi_rdata,                  // read data
   output reg  [1:0]  s_axi_rresp,                  // read response
   output reg         s_axi_rvalid,                 // read data valid
   input  wire        s_axi_rready                  // read data ready
);
   // ------------------------------------------------------------
   // states
   // ------------------------------------------------------------
   localparam ST_IDLE = 2'b00;
   localparam ST_SAVE = 2'b01;
   localparam ST_LOAD = 2'b10;

   reg [1:0]  state_reg;
   reg [3:0]  save_cnt_reg;
   reg [1:0]  ctrl_reg;
   reg [63:0] tcs_reg;
   reg [63:0] aep_reg;
   reg [31:0] flags_reg;
   reg [63:0] feature_request_mask_reg;
   reg [63:0] cr2_reg;
   reg [31:0] misc_reg;
   reg [31:0] fpu_reg;
   reg [31:0] simd_reg;
   reg [4:0]  cause_reg;
   reg        done_reg;

   wire mode64 = ctrl_reg[`EESS_CTRL_MODE64_BIT];
   wire [63:0] wmask = mode64 ? 64'hFFFFFFFFFFFFFFFF : 64'h00000000FFFFFFFF;
   wire is_mf = cause_reg[`EESS_CAUSE_MF_BIT];
   wire is_xm = cause_reg[`EESS_CAUSE_XM_BIT];
   // only a page fault that is itself the exiting event, not a direct VM exit and not raised during event delivery
   wire pf_clr = cause_reg[`EESS_CAUSE_PF_BIT] & ~cause_reg[`EESS_CAUSE_PFVM_BIT]
                 & ~cause_reg[`EESS_CAUSE_PFDLV_BIT];
   wire [63:0] ext_req = feature_request_mask_reg & ~`EESS_X87SSE_MASK
                 & (mode64 ? 64'hFFFFFFFFFFFFFFFF : ~`EESS_ONLY64_MASK);

   // ------------------------------------------------------------
   // axi write
   // ------------------------------------------------------------
   reg [7:0]  awaddr_reg;
   reg [31:0] wdata_reg;
   reg        aw_have_reg;
   reg        w_have_reg;
   wire       wr_go = aw_have_reg & w_have_reg & ~s_axi_bvalid;
   wire       wr_ok = (awaddr_reg <= `EESS_CAUSE_OFS) && (awaddr_reg[1:0] == 2'b00);

   always @(posedge aclk) begin
      if (!aresetn) begin
         awaddr_reg    <= 8'h00;
         wdata_reg     <= 32'h00000000;
         aw_have_reg   <= 1'b0;
         w_have_reg    <= 1'b0;
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= 2'b00;
      end else begin
         s_axi_awready <= ~aw_have_reg & ~s_axi_awready & s_axi_awvalid;
         s_axi_wready  <= ~w_have_reg & ~s_axi_wready & s_axi_wvalid;
         if (s_axi_awvalid && s_axi_awready) begin
            aw_have_reg <= 1'b1;
            awaddr_reg  <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_have_reg <= 1'b1;
            wdata_reg  <= s_axi_wdata;
         end
         if (wr_go) begin
            aw_have_reg  <= 1'b0;
            w_have_reg   <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_ok ? 2'b00 : 2'b10;
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // ------------------------------------------------------------
   // register file and exit sequencer
   // ------------------------------------------------------------
   wire [63:0] cr2_next = pf_clr ? (cr2_reg & `EESS_LOW12_MASK) : cr2_reg;

   always @(posedge aclk) begin
      if (!aresetn) begin
         ctrl_reg     <= 2'b00;
         tcs_reg      <= 64'h0000000000000000;
         aep_reg      <= 64'h0000000000000000;
         flags_reg    <= 32'h00000002;
         feature_request_mask_reg     <= 64'h0000000000000003;
         cr2_reg      <= 64'h0000000000000000;
         misc_reg     <= 32'h00000000;
         fpu_reg      <= 32'h00000000;
         simd_reg     <= 32'h00000000;
         cause_reg    <= 5'h00;
         state_reg    <= ST_IDLE;
         save_cnt_reg <= 4'h0;
         done_reg     <= 1'b0;
         save_req     <= 1'b0;
         state_load   <= 1'b0;
         x87sse_init  <= 1'b0;
         xinit_mask   <= 64'h0000000000000000;
         gpr_rax      <= 64'h0000000000000000;
         gpr_rbx      <= 64'h0000000000000000;
         gpr_rcx      <= 64'h0000000000000000;
         gpr_rdx      <= 64'h0000000000000000;
         gpr_rsi      <= 64'h0000000000000000;
         gpr_rdi      <= 64'h0000000000000000;
         gpr_high     <= 64'h0000000000000000;
         gpr_rip      <= 64'h0000000000000000;
         gpr_rsp      <= 64'h0000000000000000;
         gpr_rbp      <= 64'h0000000000000000;
         seg_fs_base  <= 64'h0000000000000000;
         seg_gs_base  <= 64'h0000000000000000;
      end else begin
         state_load  <= 1'b0;
         x87sse_init <= 1'b0;
         if (wr_go && wr_ok && s_axi_wready == 1'b0) begin
            case (awaddr_reg)
               `EESS_CTRL_OFS:    ctrl_reg        <= wdata_reg[1:0];
               `EESS_TCS_LO_OFS:  tcs_reg[31:0]   <= wdata_reg;
               `EESS_TCS_HI_OFS:  tcs_reg[63:32]  <= wdata_reg;
               `EESS_AEP_LO_OFS:  aep_reg[31:0]   <= wdata_reg;
               `EESS_AEP_HI_OFS:  aep_reg[63:32]  <= wdata_reg;
               `EESS_FLAGS_OFS:   flags_reg       <= wdata_reg;
               `EESS_FEATURE_REQUEST_MASK_LO_OFS: feature_request_mask_reg[31:0]  <= wdata_reg;
               `EESS_FEATURE_REQUEST_MASK_HI_OFS: feature_request_mask_reg[63:32] <= wdata_reg;
               `EESS_CR2_LO_OFS:  cr2_reg[31:0]   <= wdata_reg;
               `EESS_CR2_HI_OFS:  cr2_reg[63:32]  <= wdata_reg;
               `EESS_MISC_OFS:    misc_reg        <= wdata_reg;
               `EESS_CAUSE_OFS:   cause_reg       <= wdata_reg[4:0];
               default: ;
            endcase
         end
         case (state_reg)
            ST_IDLE: begin
               if (async_enclave_exit) begin
                  // capture first: nothing synthetic may touch state before it is saved
                  state_reg    <= ST_SAVE;
                  save_req     <= 1'b1;
                  save_cnt_reg <= 4'h0;
                  done_reg     <= 1'b0;
               end
            end
            ST_SAVE: begin
               if (save_done) begin
                  save_req  <= 1'b0;
                  state_reg <= ST_LOAD;
               end else if (save_cnt_reg != SAVE_CYCLES[3:0]) begin
                  save_cnt_reg <= save_cnt_reg + 4'h1;
               end
            end
            ST_LOAD: begin
               gpr_rax     <= `EESS_RESUME_LEAF & wmask;
               gpr_rbx     <= tcs_reg & wmask;
               gpr_rcx     <= aep_reg & wmask;
               gpr_rip     <= aep_reg & wmask;
               gpr_rdx     <= 64'h0000000000000000;
               gpr_rsi     <= 64'h0000000000000000;
               gpr_rdi     <= 64'h0000000000000000;
               gpr_high    <= mode64 ? 64'h0000000000000000 : cur_r8_r15;
               gpr_rsp     <= saved_user_stack_ptr & wmask;
               gpr_rbp     <= saved_user_frame_ptr & wmask;
               flags_reg   <= flags_reg & ~`EESS_FLAG_CLR;
               x87sse_init <= 1'b1;
               fpu_reg     <= {is_mf ? `EESS_FSW_MF : `EESS_FSW_DEF,
                               is_mf ? `EESS_FCW_MF : `EESS_FCW_DEF};
               simd_reg    <= is_xm ? `EESS_SIMD_CONTROL_STATUS_XM : `EESS_SIMD_CONTROL_STATUS_DEF;
               // misc bit 0 state is never overridden, only the fault address is trimmed
               cr2_reg     <= cr2_next;
               seg_fs_base <= entry_fs_base;
               seg_gs_base <= entry_gs_base;
               xinit_mask  <= ctrl_reg[`EESS_CTRL_OSXS_BIT] ? ext_req
                              : 64'h0000000000000000;
               state_load  <= 1'b1;
               done_reg    <= 1'b1;
               state_reg   <= ST_IDLE;
            end
            default: state_reg <= ST_IDLE;
         endcase
      end
   end

   // ------------------------------------------------------------
   // axi read
   // ------------------------------------------------------------
   reg [31:0] rd_mux;
   always @* begin
      rd_mux = 32'h00000000;
      case (s_axi_araddr)
         `EESS_CTRL_OFS:      rd_mux = {30'h0, ctrl_reg};
         `EESS_STAT_OFS:      rd_mux = {30'h0, done_reg, state_reg != ST_IDLE};
         `EESS_TCS_LO_OFS:    rd_mux = tcs_reg[31:0];
         `EESS_TCS_HI_OFS:    rd_mux = tcs_reg[63:32];
         `EESS_AEP_LO_OFS:    rd_mux = aep_reg[31:0];
         `EESS_AEP_HI_OFS:    rd_mux = aep_reg[63:32];
         `EESS_FLAGS_OFS:     rd_mux = flags_reg;
         `EESS_FEATURE_REQUEST_MASK_LO_OFS:   rd_mux = feature_request_mask_reg[31:0];
         `EESS_FEATURE_REQUEST_MASK_HI_OFS:   rd_mux = feature_request_mask_reg[63:32];
         `EESS_CR2_LO_OFS:    rd_mux = cr2_reg[31:0];
         `EESS_CR2_HI_OFS:    rd_mux = cr2_reg[63:32];
         `EESS_MISC_OFS:      rd_mux = misc_reg;
         `EESS_FPU_OFS:       rd_mux = fpu_reg;
         `EESS_SIMD_OFS:      rd_mux = simd_reg;
         `EESS_XINIT_LO_OFS:  rd_mux = xinit_mask[31:0];
         `EESS_XINIT_HI_OFS:  rd_mux = xinit_mask[63:32];
         `EESS_RESULT_LO_OFS: rd_mux = gpr_rax[31:0];
         `EESS_RESULT_HI_OFS: rd_mux = gpr_rax[63:32];
         `EESS_CAUSE_OFS:     rd_mux = {27'h0, cause_reg};
         default:             rd_mux = 32'h00000000;
      endcase
   end
   wire rd_ok = (s_axi_araddr <= `EESS_CAUSE_OFS) && (s_axi_araddr[1:0] == 2'b00);

   always @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h00000000;
         s_axi_rresp   <= 2'b00;
      end else begin
         s_axi_arready <= s_axi_arvalid & ~s_axi_arready & ~s_axi_rvalid;
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= rd_mux;
            s_axi_rresp  <= rd_ok ? 2'b00 : 2'b10;
         end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end
endmodule // eess_synth_state

// >>> hdl/eess_defs.vh
// constants for the enclave exit synthetic-state loader
// Behaviour
// - on exit, accumulator is loaded with 3, the resume leaf index.
// - on exit, base register gets the thread control struct pointer.
// - on exit, counter register and instruction pointer both get the async exit pointer.
// - data, source, destination zeroed; R8-R15 zeroed in 64-bit mode, else kept.
// - synthetic values use low 32 bits in 32-bit mode, 64 bits otherwise.
// - clear CF, PF, AF, ZF, SF, OF, RF flags; keep all other flag bits.
// - x87 and SSE state go to init state, like restore with bits 1:0 clear.
// - fpu control word 037E on fpu error fault, else 037F.
// - fpu status word 8081 on fpu error fault, else zero.
// - simd control/status 1F01 on simd fault, else 1FB0.
// - page fault not causing a VM exit clears low 12 fault-address bits.
// - page fault directly causing VM exit leaves fault address untouched.
// - page fault during event delivery does not clear low fault-address bits.
// - FS and GS restored to values of the latest enter or resume.
// - with OS extended save on, requested features in bits 63:2 go to init.
// - extended init state equals restore with mask and bitmap set to request mask.
// - in 32-bit mode, features absent in 32-bit mode stay unchanged.
// - misc features may get synthetic values only after being saved.
// - misc-select bit 0 state not overridden, but page-fault still clears low 12 bits.
// - stack and frame pointers restored from the save area before leaving.
`ifndef EESS_DEFS_VH
`define EESS_DEFS_VH
// register byte offsets
`define EESS_CTRL_OFS      8'h00
`define EESS_STAT_OFS      8'h04
`define EESS_TCS_LO_OFS    8'h08
`define EESS_TCS_HI_OFS    8'h0C
`define EESS_AEP_LO_OFS    8'h10
`define EESS_AEP_HI_OFS    8'h14
`define EESS_FLAGS_OFS     8'h18
`define EESS_FEATURE_REQUEST_MASK_LO_OFS   8'h1C
`define EESS_FEATURE_REQUEST_MASK_HI_OFS   8'h20
`define EESS_CR2_LO_OFS    8'h24
`define EESS_CR2_HI_OFS    8'h28
`define EESS_MISC_OFS      8'h2C
`define EESS_FPU_OFS       8'h30
`define EESS_SIMD_OFS      8'h34
`define EESS_XINIT_LO_OFS  8'h38
`define EESS_XINIT_HI_OFS  8'h3C
`define EESS_RESULT_LO_OFS 8'h40
`define EESS_RESULT_HI_OFS 8'h44
`define EESS_CAUSE_OFS     8'h48
// control fields
`define EESS_CTRL_MODE64_BIT 0
`define EESS_CTRL_OSXS_BIT   1
// cause field positions
`define EESS_CAUSE_MF_BIT     0
`define EESS_CAUSE_XM_BIT     1
`define EESS_CAUSE_PF_BIT     2
`define EESS_CAUSE_PFVM_BIT   3
`define EESS_CAUSE_PFDLV_BIT  4
// synthetic values
`define EESS_RESUME_LEAF  64'h0000000000000003
`define EESS_FCW_MF       16'h037E
`define EESS_FCW_DEF      16'h037F
`define EESS_FSW_MF       16'h8081
`define EESS_FSW_DEF      16'h0000
`define EESS_SIMD_CONTROL_STATUS_XM     32'h00001F01
`define EESS_SIMD_CONTROL_STATUS_DEF    32'h00001FB0
// CF PF AF ZF SF OF RF
`define EESS_FLAG_CLR     32'h000108D5
`define EESS_LOW12_MASK   64'hFFFFFFFFFFFFF000
`define EESS_X87SSE_MASK  64'h0000000000000003
// features usable only in 64-bit mode (upper vector/mask banks)
`define EESS_ONLY64_MASK  64'h00000000000000C0
`define EESS_MISC0_BIT    0
`define EESS_STAT_BUSY_BIT 0
`define EESS_STAT_DONE_BIT 1
// save and load phases
`define EESS_SAVE_CYCLES  4'h4
`endif

// >>> tb/eess_synth_monitor.sv
// concurrent checks on the exit loader ports
`timescale 1ns/100ps
module eess_synth_monitor #(
   parameter SAVE_CYCLES = 4                // save-area write budget
) (
   input wire        aclk,                  // core clock
   input wire        aresetn,               // sync reset, active low
   input wire        async_enclave_exit,    // exit request
   input wire        save_done,             // save-area write done
   input wire [63:0] saved_user_stack_ptr,  // saved stack pointer
   input wire [63:0] entry_fs_base,         // FS at entry
   input wire        save_req,              // save request
   input wire        state_load,            // load strobe
   input wire [63:0] gpr_rax,               // accumulator
   input wire [63:0] gpr_rcx,               // counter
   input wire [63:0] gpr_rdx,               // data
   input wire [63:0] gpr_rdi,               // destination
   input wire [63:0] gpr_rip,               // instruction pointer
   input wire [63:0] gpr_rsp,               // stack pointer
   input wire [63:0] seg_fs_base,           // FS base
   input wire        s_axi_bvalid,          // write response valid
   input wire        s_axi_bready,          // write response ready
   input wire [1:0]  s_axi_bresp,           // write response
   input wire        s_axi_arready,         // read address ready
   input wire        s_axi_rvalid           // read data valid
);
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   a_rax_leaf: assert property (state_load |-> gpr_rax[31:0] == 32'h3)
      else $error("accumulator not resume leaf");
   a_rcx_rip_same: assert property (state_load |-> gpr_rcx == gpr_rip)
      else $error("counter and ip differ");
   a_zero_data_regs: assert property (state_load |-> gpr_rdx == 64'h0 && gpr_rdi == 64'h0)
      else $error("data registers not zero");
   a_fs_restore: assert property (state_load |-> seg_fs_base == $past(entry_fs_base))
      else $error("fs base not restored");
   a_stack_restore: assert property (state_load |-> gpr_rsp[31:0] == $past(saved_user_stack_ptr[31:0]))
      else $error("stack pointer not restored");
   a_load_after_save: assert property (state_load |-> $past(save_done, 2) && !save_req)
      else $error("load without finished save");
   a_save_from_exit: assert property ($rose(save_req) |-> $past(async_enclave_exit))
      else $error("save request without exit");
   a_values_hold: assert property ((!state_load && !save_req && !$past(save_req))
      |-> $stable(gpr_rax) && $stable(gpr_rcx))
      else $error("synthetic values moved");
   a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped");
   a_read_answer: assert property ($rose(s_axi_arready) |=> s_axi_rvalid)
      else $error("read data late");
   c_load: cover property (state_load);
   c_wr_err: cover property (s_axi_bvalid && s_axi_bresp == 2'b10);
   c_refused: cover property (save_req && async_enclave_exit);
endmodule // eess_synth_monitor

// >>> tb/tb_top.sv
// self-checking bench for the exit synthetic-state loader
`timescale 1ns/100ps
`include "eess_defs.vh"
module tb_top;
   localparam SAVE_CYCLES = 2;
   logic        aclk, aresetn, async_enclave_exit, save_done, m64, osx;
   logic [63:0] saved_user_stack_ptr, saved_user_frame_ptr, entry_fs_base, entry_gs_base, cur_r8_r15;
   logic [63:0] thread_control_struct, async_exit_pointer, feature_request_mask, cr2;
   wire         save_req, state_load, x87sse_init;
   wire  [63:0] gpr_rax, gpr_rbx, gpr_rcx, gpr_rdx, gpr_rsi, gpr_rdi, gpr_high, gpr_rip;
   wire  [63:0] gpr_rsp, gpr_rbp, seg_fs_base, seg_gs_base, xinit_mask;
   logic [7:0]  s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, r32, flg;
   logic [3:0]  s_axi_wstrb;
   logic        s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
   wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   wire  [1:0]  s_axi_bresp, s_axi_rresp;
   wire  [31:0] s_axi_rdata;
   logic [4:0]  cause;
   logic [4:0]  ctab [6] = '{5'h00, 5'h01, 5'h02, 5'h04, 5'h0C, 5'h14};
   int          fail_count, compares, seed, i;
   eess_synth_state #(.SAVE_CYCLES(SAVE_CYCLES)) dut_u (.aclk, .aresetn, .async_enclave_exit, .save_done,
      .saved_user_stack_ptr, .saved_user_frame_ptr, .entry_fs_base, .entry_gs_base, .cur_r8_r15, .save_req,
      .state_load, .gpr_rax, .gpr_rbx, .gpr_rcx, .gpr_rdx, .gpr_rsi, .gpr_rdi, .gpr_high, .gpr_rip, .gpr_rsp,
      .gpr_rbp, .seg_fs_base, .seg_gs_base, .x87sse_init, .xinit_mask, .s_axi_awaddr,
      .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
      .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
      .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
   initial begin
      aclk = 1'b0;
      forever #2 aclk = ~aclk;
   end
   // ----------------------------------------
   // expectations and bus tasks
   // ----------------------------------------
   function automatic logic [63:0] trim(input logic [63:0] v);
      return m64 ? v : {32'h0, v[31:0]};
   endfunction
   function automatic logic [63:0] xexp();
      return osx ? (feature_request_mask & ~`EESS_X87SSE_MASK & (m64 ? ~64'h0 : ~`EESS_ONLY64_MASK)) : 64'h0;
   endfunction
   task automatic results;
      if (fail_count == 0 && compares > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
      compares++;
      if (g !== e) begin
         fail_count++;
         $display("unexpected %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic tmo(input string nm);
      fail_count++;
      $display("unexpected %s expected answer seen timeout", nm);
      results();
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      int n;
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= ~a[2]; // some writes hold the response back a cycle
      for (n = 0; n < 64; n++) begin
         @(posedge aclk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
         if (s_axi_bvalid && s_axi_bready) break;
         if (s_axi_bvalid) s_axi_bready <= 1'b1;
      end
      if (n == 64) tmo("bvalid");
      s_axi_bready <= 1'b0;
      chk("bresp", er, s_axi_bresp);
   endtask
   task automatic rchk(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er, input string nm);
      int n;
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      for (n = 0; n < 64; n++) begin
         @(posedge aclk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
         if (s_axi_rvalid) break;
      end
      if (n == 64) tmo("rvalid");
      s_axi_rready <= 1'b0;
      chk(nm, {er, e}, {s_axi_rresp, s_axi_rdata});
   endtask
   task automatic do_exit;
      int n;
      @(posedge aclk);
      async_enclave_exit <= 1'b1;
      @(posedge aclk);
      async_enclave_exit <= 1'b0;
      for (n = 0; n < 64; n++) begin
         @(posedge aclk);
         if (state_load) break;
         async_enclave_exit <= (n == 0); // second exit while busy must be ignored
         save_done <= save_req;
      end
      if (n == 64) tmo("state_load");
      save_done <= 1'b0;
      chk("x87sse_init", 64'h1, {63'h0, x87sse_init});
   endtask
   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial begin
      seed = 32'h984a71cc;
      {aresetn, async_enclave_exit, save_done, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
      {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
      {saved_user_stack_ptr, saved_user_frame_ptr, entry_fs_base, entry_gs_base, cur_r8_r15} = '0;
      s_axi_wstrb = 4'hF;
      repeat (6) @(posedge aclk);
      aresetn <= 1'b1;
      rchk(`EESS_FLAGS_OFS, 32'h2, 2'b00, "flags reset");
      rchk(`EESS_FEATURE_REQUEST_MASK_LO_OFS, 32'h3, 2'b00, "feature_request_mask reset");
      rchk(8'h4C, 32'h0, 2'b10, "unmapped read");
      wr(8'h50, 32'hFFFFFFFF, 2'b10);
      for (i = 0; i < 14; i++) begin
         r32 = $random(seed);
         m64 = r32[0];
         osx = r32[1];
         cause = (i < 6) ? ctab[i] : r32[6:2];
         flg = $random(seed);
         thread_control_struct = {$random(seed), $random(seed)};
         async_exit_pointer = {$random(seed), $random(seed)};
         cr2 = {$random(seed), $random(seed)};
         feature_request_mask = {$random(seed), $random(seed)} | 64'h3;
         saved_user_stack_ptr <= {$random(seed), $random(seed)};
         saved_user_frame_ptr <= {$random(seed), $random(seed)};
         entry_fs_base <= {$random(seed), $random(seed)};
         entry_gs_base <= {$random(seed), $random(seed)};
         cur_r8_r15 <= {$random(seed), $random(seed)};
         wr(`EESS_CTRL_OFS, {30'h0, osx, m64}, 2'b00);
         wr(`EESS_TCS_LO_OFS, thread_control_struct[31:0], 2'b00);
         wr(`EESS_TCS_HI_OFS, thread_control_struct[63:32], 2'b00);
         wr(`EESS_AEP_LO_OFS, async_exit_pointer[31:0], 2'b00);
         wr(`EESS_AEP_HI_OFS, async_exit_pointer[63:32], 2'b00);
         wr(`EESS_FLAGS_OFS, flg, 2'b00);
         wr(`EESS_FEATURE_REQUEST_MASK_LO_OFS, feature_request_mask[31:0], 2'b00);
         wr(`EESS_FEATURE_REQUEST_MASK_HI_OFS, feature_request_mask[63:32], 2'b00);
         wr(`EESS_CR2_LO_OFS, cr2[31:0], 2'b00);
         wr(`EESS_CR2_HI_OFS, cr2[63:32], 2'b00);
         wr(`EESS_MISC_OFS, {31'h0, r32[7]}, 2'b00);
         wr(`EESS_CAUSE_OFS, {27'h0, cause}, 2'b00);
         do_exit();
         chk("rax", trim(`EESS_RESUME_LEAF), gpr_rax);
         chk("rbx", trim(thread_control_struct), gpr_rbx);
         chk("rcx", trim(async_exit_pointer), gpr_rcx);
         chk("rip", trim(async_exit_pointer), gpr_rip);
         chk("rdx rsi rdi", 64'h0, gpr_rdx | gpr_rsi | gpr_rdi);
         chk("r8 to r15", m64 ? 64'h0 : cur_r8_r15, gpr_high);
         chk("rsp", trim(saved_user_stack_ptr), gpr_rsp);
         chk("rbp", trim(saved_user_frame_ptr), gpr_rbp);
         chk("fs", entry_fs_base, seg_fs_base);
         chk("gs", entry_gs_base, seg_gs_base);
         chk("xinit", xexp(), xinit_mask);
         repeat (6) @(posedge aclk);
         chk("save_req idle", 64'h0, {63'h0, save_req});
         rchk(`EESS_FLAGS_OFS, flg & ~`EESS_FLAG_CLR, 2'b00, "flags");
         r32 = (cause[4:2] == 3'b001) ? 32'hFFFFF000 : 32'hFFFFFFFF;
         rchk(`EESS_CR2_LO_OFS, cr2[31:0] & r32, 2'b00, "cr2 lo");
         rchk(`EESS_CR2_HI_OFS, cr2[63:32], 2'b00, "cr2 hi");
         r32 = cause[0] ? {`EESS_FSW_MF, `EESS_FCW_MF} : {`EESS_FSW_DEF, `EESS_FCW_DEF};
         rchk(`EESS_FPU_OFS, r32, 2'b00, "fpu");
         rchk(`EESS_SIMD_OFS, cause[1] ? `EESS_SIMD_CONTROL_STATUS_XM : `EESS_SIMD_CONTROL_STATUS_DEF, 2'b00, "simd");
         rchk(`EESS_RESULT_LO_OFS, 32'h3, 2'b00, "result");
         rchk(`EESS_STAT_OFS, 32'h2, 2'b00, "status");
      end
      results();
   end
endmodule // tb_top
bind eess_synth_state eess_synth_monitor #(.SAVE_CYCLES(SAVE_CYCLES)) mon_u (.aclk, .aresetn, .async_enclave_exit,
   .save_done, .saved_user_stack_ptr, .entry_fs_base, .save_req, .state_load, .gpr_rax, .gpr_rcx, .gpr_rdx,
   .gpr_rdi, .gpr_rip, .gpr_rsp, .seg_fs_base, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arready,
   .s_axi_rvalid);
